// [logic/plpc_top.v]
`timescale 1ns/100ps
`include "plpc_regs.vh"

module plpc_top #(
    parameter MS_CYCLES = `PLPC_CLK_HZ / `PLPC_MS_PER_S
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // avalon-mm slave
    input wire [`PLPC_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [`PLPC_DATA_W-1:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [`PLPC_DATA_W-1:0] avs_readdata,
    output reg avs_waitrequest,
    // straps, sampled once after reset release
    input wire strap_led_polarity,
    input wire strap_auto_mdix,
    input wire strap_led_mode,
    input wire [4:0] strap_phy_addr,
    // phy status
    input wire link_up,
    input wire link_100_fd,
    input wire activity,
    input wire an_active,
    input wire auto_cross_detect,
    input wire hcd_full_duplex,
    input wire [1:0] local_adv_pause,
    input wire [1:0] partner_pause,
    // outputs to pins and mac
    output reg status_led_pin,
    output reg rx_on_transmit_named_pair,
    output reg auto_mdix_active,
    output reg mac_pause_rx_en,
    output reg mac_pause_tx_en
);

    localparam [31:0] MS_LAST_FULL = MS_CYCLES - 1;
    // counter width only has to reach one millisecond of clock cycles
    localparam [`PLPC_MS_CNT_W-1:0] MS_LAST = MS_LAST_FULL[`PLPC_MS_CNT_W-1:0];

    // true when the byte address hits the given register index
    function reg_hit;
        input [`PLPC_ADDR_W-1:0] addr;
        input [5:0] idx;
        begin
            reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    // half-period of the blink in milliseconds
    function [`PLPC_BLINK_CNT_W-1:0] blink_ms;
        input [1:0] rate;
        begin
            case (rate)
                2'h0: blink_ms = `PLPC_BLINK_MS_00;
                2'h1: blink_ms = `PLPC_BLINK_MS_01;
                2'h2: blink_ms = `PLPC_BLINK_MS_10;
                default: blink_ms = `PLPC_BLINK_MS_11;
            endcase
        end
    endfunction

    // control registers
    reg [1:0] blink_rate_ff;
    reg led_pol_ff;
    reg force_sel_ff;
    reg force_val_ff;
    reg auto_mdix_ff;
    reg force_mdix_ff;
    reg bypass_str_ff;
    reg led_mode_ff;
    reg [4:0] phy_addr_ff;
    reg strap_done_ff;

    // status registers
    reg pause_rx_ff;
    reg pause_tx_ff;
    reg link_fd_ff;

    // led timing
    reg [`PLPC_MS_CNT_W-1:0] ms_cnt_ff;
    reg ms_tick_ff;
    reg [`PLPC_BLINK_CNT_W-1:0] blink_cnt_ff;
    reg blink_phase_ff;
    reg [1:0] stretch_cnt_ff;

    // bus handshake
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~avs_waitrequest;
    wire hit_led = reg_hit(avs_address, `PLPC_IDX_LED_CTRL);
    wire hit_pc = reg_hit(avs_address, `PLPC_IDX_PORT_CTRL);
    wire phase_flip;
    wire act_show;
    reg led_on;
    reg nxt_pause_rx;
    reg nxt_pause_tx;
    reg [15:0] rd_word;

    // waitrequest drops for exactly one cycle per request
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (req) begin
            avs_waitrequest <= 1'b0;
        end
    end

    // read mux; unmapped and reserved positions give zero
    always @* begin
        rd_word = 16'h0000;
        if (hit_led) begin
            rd_word[`PLPC_LED_RATE_HI:`PLPC_LED_RATE_LO] = blink_rate_ff;
            rd_word[`PLPC_LED_POL] = led_pol_ff;
            rd_word[`PLPC_LED_FORCE_SEL] = force_sel_ff;
            rd_word[`PLPC_LED_FORCE_VAL] = force_val_ff;
        end else if (hit_pc) begin
            rd_word[`PLPC_PC_AUTO_MDIX] = auto_mdix_ff;
            rd_word[`PLPC_PC_FORCE_MDIX] = force_mdix_ff;
            rd_word[`PLPC_PC_PAUSE_RX] = pause_rx_ff;
            rd_word[`PLPC_PC_PAUSE_TX] = pause_tx_ff;
            rd_word[`PLPC_PC_LINK_FD] = link_fd_ff;
            rd_word[`PLPC_PC_BYPASS_STR] = bypass_str_ff;
            rd_word[`PLPC_PC_LED_MODE] = led_mode_ff;
            rd_word[`PLPC_PC_ADDR_HI:`PLPC_PC_ADDR_LO] = phy_addr_ff;
        end
    end

    // data is loaded as waitrequest falls and holds through the answer cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_waitrequest && avs_read) begin
            avs_readdata <= {16'h0000, rd_word};
        end
    end

    // writes and strap capture; straps land on the first edge after release
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_ff <= 1'b0;
            blink_rate_ff <= `PLPC_LED_RATE_RST;
            led_pol_ff <= 1'b0;
            force_sel_ff <= `PLPC_LED_FORCE_SEL_RST;
            force_val_ff <= `PLPC_LED_FORCE_VAL_RST;
            auto_mdix_ff <= 1'b0;
            force_mdix_ff <= `PLPC_PC_FORCE_MDIX_RST;
            bypass_str_ff <= `PLPC_PC_BYPASS_STR_RST;
            led_mode_ff <= `PLPC_PC_LED_MODE_RST;
            phy_addr_ff <= `PLPC_PC_ADDR_RST;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            led_pol_ff <= strap_led_polarity;
            auto_mdix_ff <= strap_auto_mdix;
            led_mode_ff <= strap_led_mode;
            phy_addr_ff <= strap_phy_addr;
        end else if (wr_go && hit_led) begin
            if (avs_byteenable[1]) begin
                blink_rate_ff <= avs_writedata[`PLPC_LED_RATE_HI:`PLPC_LED_RATE_LO];
            end
            if (avs_byteenable[0]) begin
                led_pol_ff <= avs_writedata[`PLPC_LED_POL];
                force_sel_ff <= avs_writedata[`PLPC_LED_FORCE_SEL];
                force_val_ff <= avs_writedata[`PLPC_LED_FORCE_VAL];
            end
        end else if (wr_go && hit_pc) begin
            // read-only fields and reserved bits ignore the write
            if (avs_byteenable[1]) begin
                auto_mdix_ff <= avs_writedata[`PLPC_PC_AUTO_MDIX];
                force_mdix_ff <= avs_writedata[`PLPC_PC_FORCE_MDIX];
            end
            if (avs_byteenable[0]) begin
                bypass_str_ff <= avs_writedata[`PLPC_PC_BYPASS_STR];
                led_mode_ff <= avs_writedata[`PLPC_PC_LED_MODE];
            end
        end
    end

    // pause resolution from {asym_dir, pause} of both ends
    always @* begin
        nxt_pause_rx = 1'b0;
        nxt_pause_tx = 1'b0;
        if (hcd_full_duplex) begin
            if (local_adv_pause[`PLPC_PAUSE_SYM] && partner_pause[`PLPC_PAUSE_SYM]) begin
                nxt_pause_rx = 1'b1;
                nxt_pause_tx = 1'b1;
            end else if (!local_adv_pause[`PLPC_PAUSE_SYM] && local_adv_pause[`PLPC_PAUSE_ASYM] &&
                         partner_pause[`PLPC_PAUSE_SYM] && partner_pause[`PLPC_PAUSE_ASYM]) begin
                nxt_pause_tx = 1'b1;
            end else if (local_adv_pause[`PLPC_PAUSE_SYM] && local_adv_pause[`PLPC_PAUSE_ASYM] &&
                         !partner_pause[`PLPC_PAUSE_SYM] && partner_pause[`PLPC_PAUSE_ASYM]) begin
                nxt_pause_rx = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pause_rx_ff <= 1'b0;
            pause_tx_ff <= 1'b0;
            link_fd_ff <= 1'b0;
            mac_pause_rx_en <= 1'b0;
            mac_pause_tx_en <= 1'b0;
        end else begin
            pause_rx_ff <= nxt_pause_rx;
            pause_tx_ff <= nxt_pause_tx;
            link_fd_ff <= link_100_fd;
            mac_pause_rx_en <= nxt_pause_rx;
            mac_pause_tx_en <= nxt_pause_tx;
        end
    end

    // pair steering; a forced swap overrides the auto detector
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_on_transmit_named_pair <= 1'b0;
            auto_mdix_active <= 1'b0;
        end else begin
            auto_mdix_active <= auto_mdix_ff & an_active;
            if (force_mdix_ff) begin
                rx_on_transmit_named_pair <= 1'b1;
            end else if (auto_mdix_ff && an_active) begin
                rx_on_transmit_named_pair <= auto_cross_detect;
            end else if (!auto_mdix_ff) begin
                rx_on_transmit_named_pair <= 1'b0;
            end
        end
    end

    // millisecond tick; counter width covers the default rate only
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt_ff <= 16'h0000;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff == MS_LAST) begin
            ms_cnt_ff <= 16'h0000;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            ms_tick_ff <= 1'b0;
        end
    end

    // blink phase; a new rate applies at once to the phase in progress
    assign phase_flip = ms_tick_ff && (blink_cnt_ff >= blink_ms(blink_rate_ff) - 9'h001);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blink_cnt_ff <= 9'h000;
            blink_phase_ff <= 1'b0;
        end else if (phase_flip) begin
            blink_cnt_ff <= 9'h000;
            blink_phase_ff <= ~blink_phase_ff;
        end else if (ms_tick_ff) begin
            blink_cnt_ff <= blink_cnt_ff + 9'h001;
        end
    end

    // stretch: hold activity until the second phase boundary after it ends
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stretch_cnt_ff <= 2'h0;
        end else if (activity) begin
            stretch_cnt_ff <= 2'h2;
        end else if (phase_flip && stretch_cnt_ff != 2'h0) begin
            stretch_cnt_ff <= stretch_cnt_ff - 2'h1;
        end
    end

    // bypass shows the raw activity level, so short bursts may be invisible
    assign act_show = bypass_str_ff ? activity : (stretch_cnt_ff != 2'h0);

    always @* begin
        if (led_mode_ff) begin
            led_on = link_up;
        end else if (bypass_str_ff) begin
            led_on = link_up & ~act_show;
        end else begin
            led_on = link_up & ~(act_show & blink_phase_ff);
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_led_pin <= 1'b1;
        end else if (force_sel_ff) begin
            status_led_pin <= force_val_ff;
        end else begin
            status_led_pin <= led_pol_ff ? led_on : ~led_on;
        end
    end

endmodule // plpc_top

// [logic/plpc_regs.vh]
`ifndef PLPC_REGS_VH
`define PLPC_REGS_VH

// register indexes; byte address is four times the index
`define PLPC_IDX_LED_CTRL 6'h18
`define PLPC_IDX_PORT_CTRL 6'h19
`define PLPC_ADDR_W 8
`define PLPC_DATA_W 32

// status_led_control fields
`define PLPC_LED_RATE_HI 10
`define PLPC_LED_RATE_LO 9
`define PLPC_LED_POL 7
`define PLPC_LED_FORCE_SEL 4
`define PLPC_LED_FORCE_VAL 1
`define PLPC_LED_RATE_RST 2'h2
`define PLPC_LED_FORCE_SEL_RST 1'h0
`define PLPC_LED_FORCE_VAL_RST 1'h0

// port_control_status fields
`define PLPC_PC_AUTO_MDIX 15
`define PLPC_PC_FORCE_MDIX 14
`define PLPC_PC_PAUSE_RX 13
`define PLPC_PC_PAUSE_TX 12
`define PLPC_PC_LINK_FD 11
`define PLPC_PC_BYPASS_STR 7
`define PLPC_PC_LED_MODE 5
`define PLPC_PC_ADDR_HI 4
`define PLPC_PC_ADDR_LO 0
`define PLPC_PC_FORCE_MDIX_RST 1'h0
`define PLPC_PC_BYPASS_STR_RST 1'h0
`define PLPC_PC_LED_MODE_RST 1'h1
`define PLPC_PC_ADDR_RST 5'h01

// pause bits inside the advertisement words: {asym_dir, pause}
`define PLPC_PAUSE_SYM 0
`define PLPC_PAUSE_ASYM 1

// timing
`define PLPC_CLK_HZ 40000000
`define PLPC_MS_PER_S 1000
`define PLPC_BLINK_MS_00 9'h032
`define PLPC_BLINK_MS_01 9'h064
`define PLPC_BLINK_MS_10 9'h0C8
`define PLPC_BLINK_MS_11 9'h1F4
`define PLPC_BLINK_CNT_W 9
`define PLPC_MS_CNT_W 16

`endif

// [bench/plpc_led_model.sv]
`timescale 1ns/100ps
module plpc_led_model (
    // clock and reset
    input wire clk,
    input wire rstn,
    // led pin and the polarity it is wired for
    input wire status_led_pin,
    input wire active_high,
    // indicator view
    output wire lit,
    output reg [15:0] gap_ff,
    output reg [7:0] flips_ff
);
    reg [15:0] run_ff;
    reg last_ff;
    // a low pin lights the lamp when it is wired active low
    assign lit = active_high ? status_led_pin : !status_led_pin;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 16'h0000;
            gap_ff <= 16'h0000;
            flips_ff <= 8'h00;
            last_ff <= 1'h0;
        end else begin
            run_ff <= (lit != last_ff) ? 16'h0000 : run_ff + 16'h0001;
            last_ff <= lit;
            if (lit != last_ff) begin
                gap_ff <= run_ff + 16'h0001;
                flips_ff <= flips_ff + 8'h01;
            end
        end
    end
endmodule // plpc_led_model

// [bench/plpc_top_props.sv]
`timescale 1ns/100ps
module plpc_props (
    // clock, reset and bus
    input wire clk,
    input wire rstn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // straps and status
    input wire [4:0] strap_phy_addr,
    input wire link_100_fd,
    input wire an_active,
    input wire hcd_full_duplex,
    input wire [1:0] local_adv_pause,
    input wire [1:0] partner_pause,
    // outputs
    input wire status_led_pin,
    input wire auto_mdix_active,
    input wire mac_pause_rx_en,
    input wire mac_pause_tx_en
);
    wire done = !avs_waitrequest && (avs_read || avs_write);
    wire port_rd = done && avs_read && avs_address == 8'h64;
    wire led_wr = done && avs_write && avs_address == 8'h60 && avs_byteenable[0];
    wire [31:0] rmask = avs_address == 8'h60 ? 32'hFFFFF96D : avs_address == 8'h64 ? 32'hFFFF0740 : 32'hFFFFFFFF;
    wire both = local_adv_pause[1] & partner_pause[1];
    wire [1:0] pexp = {2{hcd_full_duplex}} & {local_adv_pause[0] & (partner_pause[0] | both),
        partner_pause[0] & (local_adv_pause[0] | both)};
    reg sel_ff;
    reg val_ff;
    // shadow of the force bits, both live in byte lane 0
    always @(posedge clk or negedge rstn)
        if (!rstn) {sel_ff, val_ff} <= 2'h0;
        else if (led_wr) {sel_ff, val_ff} <= {avs_writedata[4], avs_writedata[1]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low twice");
    pause_table_a: assert property (1'h1 |=> {mac_pause_rx_en, mac_pause_tx_en} == $past(pexp))
        else $error("pause flags off table");
    pause_off_a: assert property (!hcd_full_duplex |=> !mac_pause_rx_en && !mac_pause_tx_en)
        else $error("pause flags without full duplex");
    link_fd_a: assert property (port_rd |-> avs_readdata[11] == link_100_fd) else $error("link bit wrong");
    rsvd_zero_a: assert property (done && avs_read |-> (avs_readdata & rmask) == 32'h0)
        else $error("reserved bits set");
    addr_ro_a: assert property (port_rd |-> avs_readdata[4:0] == strap_phy_addr) else $error("address wrong");
    auto_gate_a: assert property (auto_mdix_active |-> $past(an_active)) else $error("crossover detect idle");
    force_pin_a: assert property (sel_ff |=> status_led_pin == $past(val_ff)) else $error("forced led wrong");
    cover property (port_rd);
    cover property (mac_pause_rx_en && !mac_pause_tx_en);
    cover property (sel_ff && status_led_pin);
endmodule // plpc_props
bind plpc_top plpc_props plpc_props_inst (.*);

// [bench/plpc_top_bench.sv]
`timescale 1ns/100ps
`include "plpc_regs.vh"
module plpc_top_bench;
    localparam MS = 10;
    reg clk = 1'h0;
    reg rstn = 1'h0;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'h0;
    reg avs_write = 1'h0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'h0;
    reg strap_led_polarity = 1'h0, strap_auto_mdix = 1'h0, strap_led_mode = 1'h0;
    reg [4:0] strap_phy_addr = 5'h00;
    reg link_up = 1'h0, link_100_fd = 1'h0, activity = 1'h0;
    reg an_active = 1'h0, auto_cross_detect = 1'h0, hcd_full_duplex = 1'h0;
    reg [1:0] local_adv_pause = 2'h0, partner_pause = 2'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, status_led_pin, rx_on_transmit_named_pair;
    wire auto_mdix_active, mac_pause_rx_en, mac_pause_tx_en, lit;
    wire [15:0] gap;
    wire [7:0] flips;
    integer failures = 0, samples_checked = 0, seed = 83, i;
    reg [15:0] led_m = 16'h0, port_m = 16'h0;
    reg [31:0] rv;
    plpc_top #(.MS_CYCLES(MS)) plpc_top_inst (.*);
    plpc_led_model plpc_led_model_inst (.clk(clk), .rstn(rstn), .status_led_pin(status_led_pin),
        .active_high(led_m[7]), .lit(lit), .gap_ff(gap), .flips_ff(flips));
    always #12.5 clk = ~clk;
    function [1:0] pres(input h, input [1:0] l, input [1:0] p);
        pres = {l[0] & (p[0] | (l[1] & p[1])), p[0] & (l[0] | (l[1] & p[1]))} & {2{h}};
    endfunction
    function [31:0] port_exp();
        port_exp = {16'h0, port_m | {2'h0, pres(hcd_full_duplex, local_adv_pause, partner_pause),
            link_100_fd, 6'h00, strap_phy_addr}};
    endfunction
    function [31:0] blink_len(input [1:0] r);
        blink_len = MS * (r == 2'h0 ? `PLPC_BLINK_MS_00 : r == 2'h1 ? `PLPC_BLINK_MS_01 :
            r == 2'h2 ? `PLPC_BLINK_MS_10 : `PLPC_BLINK_MS_11);
    endfunction
    task test_done;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task bail;
        failures = failures + 1;
        test_done;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // hold the request until the rising edge that sees waitrequest low; data taken at that edge
    task bus(input wr, input [7:0] a, input [31:0] d, input [3:0] be);
        integer k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        k = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0 && k < 20) begin
            @(posedge clk);
            k = k + 1;
        end
        if (k >= 20)
            bail;
        rv = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task wreg(input [7:0] a, input [31:0] d, input [3:0] be);
        reg [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        bus(1'h1, a, d, be);
        if (a == 8'h60)
            led_m = (led_m & ~m) | (d[15:0] & m & 16'h0692);
        if (a == 8'h64)
            port_m = (port_m & ~m) | (d[15:0] & m & 16'hC0A0);
    endtask
    task rreg(input [7:0] a, input [31:0] exp);
        bus(1'h0, a, 32'h0, 4'hF);
        chk(rv, exp);
    endtask
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task do_reset;
        @(posedge clk);
        rv = $random(seed);
        rstn <= 1'h0;
        {strap_led_polarity, strap_auto_mdix, strap_led_mode, strap_phy_addr} <= rv[7:0];
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        led_m = {5'h00, 2'h2, 1'h0, strap_led_polarity, 7'h00};
        port_m = {strap_auto_mdix, 9'h000, strap_led_mode, 5'h00};
    endtask
    // the first flip after a rate change may be short, so measure the third
    task wait_flips;
        reg [7:0] s;
        integer t;
        s = flips;
        t = 0;
        while (flips - s != 8'h03 && t < 20000) begin
            @(posedge clk);
            t = t + 1;
        end
        if (t >= 20000)
            bail;
    endtask
    initial begin
        do_reset;
        rreg(8'h60, {16'h0, led_m});
        rreg(8'h64, port_exp());
        for (i = 0; i < 16; i = i + 1) begin
            rv = $random(seed);
            wreg({5'h0C, i[0], 2'h0}, $random(seed), rv[3:0]);
            rreg(8'h60, {16'h0, led_m});
            rreg(8'h64, port_exp());
        end
        wreg(8'h68, 32'hFFFF, 4'hF);
        rreg(8'h68, 32'h0);
        rreg(8'h60, {16'h0, led_m});
        $display("register test done");
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge clk);
            {link_100_fd, hcd_full_duplex, local_adv_pause, partner_pause} <= i[5:0];
            @(posedge clk);
            @(negedge clk);
            rv = {30'h0, pres(hcd_full_duplex, local_adv_pause, partner_pause)};
            chk({30'h0, mac_pause_rx_en, mac_pause_tx_en}, rv);
            if (i[2:0] == 3'h5)
                rreg(8'h64, port_exp());
        end
        $display("pause test done");
        wreg(8'h64, 32'h4000, 4'h3);
        settle;
        chk({31'h0, rx_on_transmit_named_pair}, 32'h1);
        @(posedge clk);
        an_active <= 1'h1;
        auto_cross_detect <= 1'h1;
        wreg(8'h64, 32'h8000, 4'h3);
        settle;
        chk({30'h0, rx_on_transmit_named_pair, auto_mdix_active}, 32'h3);
        @(posedge clk);
        an_active <= 1'h0;
        settle;
        chk({31'h0, auto_mdix_active}, 32'h0);
        wreg(8'h64, 32'h0020, 4'h3);
        link_up <= 1'h1;
        settle;
        chk({31'h0, rx_on_transmit_named_pair}, 32'h0);
        $display("pair test done");
        for (i = 0; i < 8; i = i + 1) begin
            wreg(8'h60, {24'h0, i[0], 2'h0, i[2], 2'h0, i[1], 1'h0}, 4'h3);
            settle;
            chk({31'h0, status_led_pin}, {31'h0, i[2] ? i[1] : i[0]});
        end
        wreg(8'h64, 32'h0, 4'h3);
        activity <= 1'h1;
        for (i = 0; i < 4; i = i + 1) begin
            wreg(8'h60, {21'h0, i[1:0], 9'h080}, 4'h3);
            wait_flips;
            chk({16'h0, gap}, blink_len(i[1:0]));
        end
        wreg(8'h64, 32'h0080, 4'h3);
        settle;
        chk({31'h0, status_led_pin}, 32'h0);
        @(posedge clk);
        activity <= 1'h0;
        settle;
        chk({31'h0, status_led_pin}, 32'h1);
        $display("led test done");
        do_reset;
        rreg(8'h60, {16'h0, led_m});
        rreg(8'h64, port_exp());
        $display("reset test done");
        test_done;
    end
endmodule // plpc_top_bench
